//--- dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	localparam FRAME = 200;
	logic       core_clk, resetn, reg_write, reg_read;
	logic [7:0] reg_addr, reg_wdata, rdat;
	logic       speed_select, transceiver_enable, got;
	logic [2:0] clock_select;
	logic [3:1] split_mode, endpoint_direction_select;
	logic [3:1] in_double_buffer, out_double_buffer;
	wire  [7:0] reg_rdata, usb_out_data, usb_in_data;
	wire        full_speed_reg, recovery_locked, recovery_active, frame_pin;
	wire  [2:0] usb_clock_source_reg;
	wire  [6:0] oscillator_trim_value, buffer_empty, buffer_full;
	wire  [1:0] usb_out_ep, usb_in_ep;
	wire        usb_out_valid, usb_out_ready, usb_in_req, usb_in_valid;
	wire  [9:0] usb_in_max_packet, usb_out_max_packet;
	int         fail_count, tests_run;
	usb_endpoint_buffer #(.FRAME_CYCLES(FRAME)) usb_endpoint_buffer_inst (
		.core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
		.reg_rdata(reg_rdata), .speed_select(speed_select),
		.transceiver_enable(transceiver_enable), .clock_select(clock_select),
		.split_mode(split_mode),
		.endpoint_direction_select(endpoint_direction_select),
		.in_double_buffer(in_double_buffer),
		.out_double_buffer(out_double_buffer),
		.full_speed_reg(full_speed_reg),
		.usb_clock_source_reg(usb_clock_source_reg),
		.oscillator_trim_value(oscillator_trim_value),
		.recovery_locked(recovery_locked), .recovery_active(recovery_active),
		.frame_pin(frame_pin), .usb_out_ep(usb_out_ep),
		.usb_out_data(usb_out_data), .usb_out_valid(usb_out_valid),
		.usb_out_ready(usb_out_ready), .usb_in_ep(usb_in_ep),
		.usb_in_req(usb_in_req), .usb_in_data(usb_in_data),
		.usb_in_valid(usb_in_valid), .usb_in_max_packet(usb_in_max_packet),
		.usb_out_max_packet(usb_out_max_packet),
		.buffer_empty(buffer_empty), .buffer_full(buffer_full));
	usb_host_model host_inst (.core_clk(core_clk), .usb_out_ep(usb_out_ep),
		.usb_out_data(usb_out_data), .usb_out_valid(usb_out_valid),
		.usb_out_ready(usb_out_ready), .usb_in_ep(usb_in_ep),
		.usb_in_req(usb_in_req), .usb_in_data(usb_in_data),
		.usb_in_valid(usb_in_valid), .frame_pin(frame_pin));
	// ==========================================================
	// Bus tasks and comparison.
	task check(input string what, input logic [9:0] seen, input logic [9:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge core_clk);
		reg_addr = a;
		reg_wdata = d;
		reg_write = 1'b1;
		@(negedge core_clk);
		reg_write = 1'b0;
	endtask
	task rdchk(input logic [7:0] a, input logic [7:0] exp, input string what);
		@(negedge core_clk);
		reg_addr = a;
		reg_read = 1'b1;
		@(negedge core_clk);
		reg_read = 1'b0;
		@(negedge core_clk);
		check(what, {2'b00, reg_rdata}, {2'b00, exp});
	endtask
	function automatic logic [9:0] mp(input int ep, input logic sp,
		input logic db);
		mp = 10'h040 << ep;
		if (ep != 0)
			mp = mp >> (int'(sp) + int'(db));
	endfunction
	task print_verdict;
		$display("Checks %0d, mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// ==========================================================
	// Clock, watchdog and test sequence.
	initial
	begin
		core_clk = 1'b0;
		forever
			#5 core_clk = ~core_clk;
	end
	initial
	begin
		#300000;
		fail_count++;
		print_verdict();
	end
	initial
	begin
		{fail_count, tests_run} = 0;
		{resetn, reg_write, reg_read, reg_addr, reg_wdata} = 0;
		{speed_select, transceiver_enable, clock_select} = 0;
		{split_mode, endpoint_direction_select} = 0;
		{in_double_buffer, out_double_buffer} = 0;
		repeat (3) @(negedge core_clk);
		resetn = 1'b1;
		check("empty", {3'b000, buffer_empty}, 10'h07F);
		rdchk(8'h0F, 8'h09, "recovery reset");
		rdchk(8'h30, 8'h00, "unmapped");
		wr(8'h0F, 8'hE0);
		rdchk(8'h0F, 8'hE9, "reserved");
		for (int i = 0; i < 8; i++)
		begin
			clock_select = 3'(i);
			speed_select = i[0];
			repeat (2) @(negedge core_clk);
			check("source", {7'h00, usb_clock_source_reg},
				10'(i));
			check("speed", {9'h000, full_speed_reg},
				{9'h000, i[0]});
		end
		wr(8'h0F, 8'h89);
		check("no transceiver", {9'h000, recovery_active}, 10'h000);
		transceiver_enable = 1'b1;
		speed_select = 1'b0;
		@(negedge core_clk);
		check("low plain", {9'h000, recovery_active}, 10'h000);
		wr(8'h0F, 8'hA9);
		check("low on", {9'h000, recovery_active}, 10'h001);
		speed_select = 1'b1;
		wr(8'h0F, 8'h89);
		@(negedge core_clk);
		check("full on", {9'h000, recovery_active}, 10'h001);
		host_inst.frames(4, FRAME);
		check("locked", {9'h000, recovery_locked}, 10'h001);
		host_inst.frames(3, FRAME + 60);
		check("slow", {3'b000, oscillator_trim_value}, 10'h048);
		wr(8'h0F, 8'hC9);
		host_inst.frames(3, FRAME - 60);
		check("fine", {3'b000, oscillator_trim_value}, 10'h047);
		wr(8'h0F, 8'h09);
		host_inst.frames(2, FRAME - 60);
		check("off", {3'b000, oscillator_trim_value}, 10'h047);
		for (int i = 0; i < 80; i++)
			host_inst.send_out(2'd0, 8'(i));
		@(negedge core_clk);
		check("ep0 full", {9'h000, buffer_full[0]}, 10'h001);
		check("stalled", {9'h000, usb_out_ready}, 10'h000);
		for (int i = 0; i < 80; i++)
			rdchk(8'h20, 8'(i), "ep0 byte");
		for (int i = 0; i < 65; i++)
			wr(8'h20, 8'(i + 100));
		for (int i = 0; i < 65; i++)
		begin
			host_inst.request_in(2'd0, rdat, got);
			check("ep0 in", {got, 1'b0, got ? rdat : 8'h00},
				(i < 64) ? {2'b10, 8'(i + 100)} : 10'h000);
		end
		split_mode = 3'b100;
		wr(8'h23, 8'hA5);
		check("ep3 halves", {8'h00, buffer_empty[6:5]}, 10'h002);
		rdchk(8'h23, 8'h00, "ep3 out empty");
		host_inst.send_out(2'd3, 8'h3C);
		repeat (3) @(negedge core_clk);
		rdchk(8'h23, 8'h3C, "ep3 out");
		host_inst.request_in(2'd3, rdat, got);
		check("ep3 in", {1'b0, got, rdat}, 10'h1A5);
		split_mode = 3'b000;
		endpoint_direction_select = 3'b001;
		wr(8'h21, 8'h5A);
		rdchk(8'h21, 8'h00, "ep1 read refused");
		host_inst.request_in(2'd1, rdat, got);
		check("ep1 in", {1'b0, got, rdat}, 10'h15A);
		endpoint_direction_select = 3'b000;
		wr(8'h21, 8'h11);
		check("ep1 write refused", {9'h000, buffer_empty[1]},
			10'h001);
		host_inst.send_out(2'd1, 8'h77);
		repeat (3) @(negedge core_clk);
		rdchk(8'h21, 8'h77, "ep1 out");
		for (int ep = 0; ep < 4; ep++)
			for (int c = 0; c < 8; c++)
			begin
				host_inst.point(2'(ep));
				split_mode = {3{c[0]}};
				in_double_buffer = {3{c[1]}};
				out_double_buffer = {3{c[2]}};
				repeat (2) @(negedge core_clk);
				check("in size", usb_in_max_packet,
					mp(ep, c[0], c[1]));
				check("out size", usb_out_max_packet,
					mp(ep, c[0], c[0] ? c[2] : c[1]));
			end
		print_verdict();
	end
endmodule // tb_top

//--- dv/usb_buffer_checker.sv
`timescale 1ns/1ps
module usb_buffer_checker
(
	// Clock and reset.
	input logic       core_clk,
	input logic       resetn,
	// Register port.
	input logic [7:0] reg_addr,
	input logic [7:0] reg_wdata,
	input logic       reg_write,
	input logic       reg_read,
	input logic [7:0] reg_rdata,
	// Configuration and clock status.
	input logic       speed_select,
	input logic       transceiver_enable,
	input logic [2:0] clock_select,
	input logic       full_speed_reg,
	input logic [2:0] usb_clock_source_reg,
	input logic [6:0] oscillator_trim_value,
	input logic       recovery_active,
	// USB IN side.
	input logic [1:0] usb_in_ep,
	input logic       usb_in_req,
	input logic       usb_in_valid,
	input logic [9:0] usb_in_max_packet
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);
	// ==========================================================
	// Register port.
	chk_unmapped_zero: assert property (
		reg_read && !(reg_addr inside {8'h0F, [8'h20:8'h23]}) ##1 !reg_read
		|=> reg_rdata == 8'h00) else $error("unmapped read not zero");
	chk_reserved_bits: assert property (
		reg_read && reg_addr == 8'h0F ##1 !reg_read
		|=> reg_rdata[4:0] == 5'h09) else $error("reserved bits wrong");
	chk_recovery_off: assert property (
		reg_write && reg_addr == 8'h0F && !reg_wdata[7]
		|=> !recovery_active) else $error("recovery not off");
	chk_recovery_on: assert property (
		reg_write && reg_addr == 8'h0F && reg_wdata[7] && transceiver_enable
		&& full_speed_reg ##1 transceiver_enable && full_speed_reg
		|-> recovery_active) else $error("recovery not on");
	chk_needs_transceiver: assert property (
		recovery_active |-> transceiver_enable)
		else $error("recovery without transceiver");
	// ==========================================================
	// Clock selection and trim.
	chk_speed_follows: assert property (
		$stable(speed_select) ##1 $stable(speed_select)
		|-> full_speed_reg == speed_select) else $error("speed not followed");
	chk_source_follows: assert property (
		$changed(clock_select) |=> usb_clock_source_reg == $past(clock_select))
		else $error("clock source not followed");
	chk_trim_step: assert property (
		$changed(oscillator_trim_value) |->
		7'(oscillator_trim_value - $past(oscillator_trim_value))
		inside {[7'd1:7'd4], [7'd124:7'd127]}) else $error("trim step too big");
	// ==========================================================
	// USB IN side.
	chk_ep0_packet: assert property (
		usb_in_ep == 2'd0 |=> usb_in_max_packet == 10'd64)
		else $error("endpoint zero packet size wrong");
	chk_valid_cause: assert property (
		$rose(usb_in_valid) |-> $past(usb_in_req))
		else $error("IN byte without request");
endmodule // usb_buffer_checker

bind usb_endpoint_buffer usb_buffer_checker usb_buffer_checker_inst
(
	.core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
	.reg_rdata(reg_rdata), .speed_select(speed_select),
	.transceiver_enable(transceiver_enable), .clock_select(clock_select),
	.full_speed_reg(full_speed_reg),
	.usb_clock_source_reg(usb_clock_source_reg),
	.oscillator_trim_value(oscillator_trim_value),
	.recovery_active(recovery_active), .usb_in_ep(usb_in_ep),
	.usb_in_req(usb_in_req), .usb_in_valid(usb_in_valid),
	.usb_in_max_packet(usb_in_max_packet)
);

//--- dv/usb_host_model.sv
`timescale 1ns/1ps
module usb_host_model
(
	// Clock.
	input  logic       core_clk,
	// OUT stream.
	output logic [1:0] usb_out_ep,
	output logic [7:0] usb_out_data,
	output logic       usb_out_valid,
	input  logic       usb_out_ready,
	// IN stream.
	output logic [1:0] usb_in_ep,
	output logic       usb_in_req,
	input  logic [7:0] usb_in_data,
	input  logic       usb_in_valid,
	// Frame marker.
	output logic       frame_pin
);
	initial
	begin
		usb_out_ep = 2'h0;
		usb_out_data = 8'h00;
		usb_out_valid = 1'b0;
		usb_in_ep = 2'h0;
		usb_in_req = 1'b0;
		frame_pin = 1'b0;
	end
	// Sends one byte; a released data line shows the inverse value.
	task send_out(input logic [1:0] ep, input logic [7:0] d);
		@(negedge core_clk);
		usb_out_ep = ep;
		usb_out_data = d;
		usb_out_valid = 1'b1;
		while (usb_out_ready !== 1'b1)
			@(negedge core_clk);
		@(negedge core_clk);
		usb_out_valid = 1'b0;
		usb_out_data = ~d;
	endtask
	task request_in(input logic [1:0] ep, output logic [7:0] d,
		output logic got);
		@(negedge core_clk);
		usb_in_ep = ep;
		usb_in_req = 1'b1;
		@(negedge core_clk);
		usb_in_req = 1'b0;
		got = usb_in_valid;
		d = usb_in_data;
		if (got !== 1'b1)
		begin
			@(negedge core_clk);
			got = usb_in_valid;
			d = usb_in_data;
		end
	endtask
	task point(input logic [1:0] ep);
		@(negedge core_clk);
		usb_in_ep = ep;
		usb_out_ep = ep;
	endtask
	// Frame markers with a fixed spacing in core cycles.
	task frames(input int n, input int period);
		repeat (n)
		begin
			frame_pin = 1'b1;
			repeat (4) @(negedge core_clk);
			frame_pin = 1'b0;
			repeat (period - 4) @(negedge core_clk);
		end
	endtask
endmodule // usb_host_model

//--- rtl/byte_fifo.v
`timescale 1ns/1ps
module byte_fifo
#(
	parameter WIDTH = 10,
	parameter DEPTH = 16,
	parameter AW    = 4
)
(
	// Clock and reset.
	input  wire             core_clk,
	input  wire             resetn,
	// Filling side.
	input  wire             in_valid,
	input  wire [WIDTH-1:0] in_data,
	output wire             in_ready,
	// Draining side.
	output wire             out_valid,
	output wire [WIDTH-1:0] out_data,
	input  wire             out_ready
);
	reg  [WIDTH-1:0] store [0:DEPTH-1];
	reg  [AW-1:0]    wr_reg;
	reg  [AW-1:0]    rd_reg;
	reg  [AW:0]      count_reg;
	wire             do_push;
	wire             do_pop;

	assign in_ready  = (count_reg != DEPTH[AW:0]);
	assign out_valid = (count_reg != {(AW+1){1'b0}});
	assign out_data  = store[rd_reg];
	assign do_push   = in_valid & in_ready;
	assign do_pop    = out_valid & out_ready;

	always @(posedge core_clk)
	begin
		if (do_push)
			store[wr_reg] <= in_data;
	end

	always @(posedge core_clk)
	begin
		if (!resetn)
		begin
			wr_reg    <= {AW{1'b0}};
			rd_reg    <= {AW{1'b0}};
			count_reg <= {(AW+1){1'b0}};
		end
		else
		begin
			if (do_push)
				wr_reg <= (wr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
					: wr_reg + 1'b1;
			if (do_pop)
				rd_reg <= (rd_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
					: rd_reg + 1'b1;
			if (do_push && !do_pop)
				count_reg <= count_reg + 1'b1;
			else if (do_pop && !do_push)
				count_reg <= count_reg - 1'b1;
		end
	end
endmodule // byte_fifo

//--- rtl/oscillator_trim.v
`timescale 1ns/1ps
`include "usb_buffer_map.vh"
module oscillator_trim
#(
	parameter FRAME_CYCLES = `FRAME_CYCLES,
	parameter CNT_W        = 20
)
(
	// Clock and reset.
	input  wire       core_clk,
	input  wire       resetn,
	// Control.
	input  wire       recovery_on,
	input  wire       single_step,
	// Frame marker pin from the link.
	input  wire       frame_pin,
	// Trim result.
	output reg  [6:0] trim_reg,
	output reg        locked_reg
);
	localparam integer     HIGH_SUM   = FRAME_CYCLES + `LOCK_TOLERANCE;
	localparam integer     LOW_SUM    = FRAME_CYCLES - `LOCK_TOLERANCE;
	localparam [CNT_W-1:0] HIGH_LIMIT = HIGH_SUM[CNT_W-1:0];
	localparam [CNT_W-1:0] LOW_LIMIT  = LOW_SUM[CNT_W-1:0];
	reg  [2:0]       sync_reg;
	reg              level_reg;
	reg              seen_reg;
	reg  [CNT_W-1:0] period_reg;
	wire             tick;
	wire [6:0]       step;

	assign tick = (sync_reg[1] == sync_reg[2]) & sync_reg[1] & ~level_reg;
	assign step = single_step ? `TRIM_FINE_STEP : `TRIM_COARSE_STEP;

	always @(posedge core_clk)
	begin
		if (!resetn)
		begin
			sync_reg   <= 3'h0;
			level_reg  <= 1'b0;
			seen_reg   <= 1'b0;
			period_reg <= {CNT_W{1'b0}};
			trim_reg   <= `TRIM_RESET;
			locked_reg <= 1'b0;
		end
		else
		begin
			sync_reg <= {sync_reg[1:0], frame_pin};
			if (sync_reg[1] == sync_reg[2])
				level_reg <= sync_reg[1];
			if (!recovery_on)
			begin
				seen_reg   <= 1'b0;
				locked_reg <= 1'b0;
			end
			else if (tick)
			begin
				seen_reg <= 1'b1;
				if (seen_reg && period_reg > HIGH_LIMIT)
				begin
					trim_reg   <= (trim_reg > 7'h7F - step) ? 7'h7F
						: trim_reg + step;
					locked_reg <= 1'b0;
				end
				else if (seen_reg && period_reg < LOW_LIMIT)
				begin
					trim_reg   <= (trim_reg < step) ? 7'h00
						: trim_reg - step;
					locked_reg <= 1'b0;
				end
				else if (seen_reg)
					locked_reg <= 1'b1;
			end
			if (tick)
				period_reg <= {CNT_W{1'b0}};
			else if (period_reg != {CNT_W{1'b1}})
				period_reg <= period_reg + 1'b1;
		end
	end
endmodule // oscillator_trim

//--- rtl/usb_buffer_map.vh
`ifndef USB_BUFFER_MAP_VH
`define USB_BUFFER_MAP_VH
// ==========================================================================
// Controller register addresses.
`define CLOCK_RECOVERY_ADDR      8'h0F
`define BYTE_PORT_FIRST          8'h20
`define BYTE_PORT_LAST           8'h23
// ==========================================================================
// Recovery control fields and reset value.
`define CLOCK_RECOVERY_RESET     8'h09
`define RECOVERY_ENABLE_BIT      7
`define SINGLE_STEP_BIT          6
`define LOW_SPEED_RECOVERY_BIT   5
`define RESERVED_PATTERN         5'h09
// ==========================================================================
// Endpoint buffer placement inside the 1024-byte buffer RAM.
`define BUFFER_BYTES             1024
`define EP0_BASE                 10'h000
`define EP3_BASE                 10'h040
`define EP2_BASE                 10'h240
`define EP1_BASE                 10'h340
`define EP0_SIZE                 10'h040
`define EP1_SIZE                 10'h080
`define EP2_SIZE                 10'h100
`define EP3_SIZE                 10'h200
// ==========================================================================
// Clock recovery timing.
`define CORE_CLK_MHZ             100
`define FRAME_PERIOD_US          1000
`define FRAME_PERIOD_NS          1000000
`define CORE_PERIOD_NS           10
`define FRAME_CYCLES             (`FRAME_PERIOD_NS / `CORE_PERIOD_NS)
`define LOCK_TOLERANCE           16
`define TRIM_RESET               7'h40
`define TRIM_COARSE_STEP         7'h04
`define TRIM_FINE_STEP           7'h01
`endif

//--- rtl/usb_endpoint_buffer.v
`timescale 1ns/1ps
`include "usb_buffer_map.vh"
module usb_endpoint_buffer
#(
	parameter FRAME_CYCLES = `FRAME_CYCLES,
	parameter FIFO_DEPTH   = 16
)
(
	// Clock and reset.
	input  wire       core_clk,
	input  wire       resetn,
	// Controller register port.
	input  wire [7:0] reg_addr,
	input  wire [7:0] reg_wdata,
	input  wire       reg_write,
	input  wire       reg_read,
	output reg  [7:0] reg_rdata,
	// Device configuration.
	input  wire       speed_select,
	input  wire       transceiver_enable,
	input  wire [2:0] clock_select,
	input  wire [3:1] split_mode,
	input  wire [3:1] endpoint_direction_select,
	input  wire [3:1] in_double_buffer,
	input  wire [3:1] out_double_buffer,
	// Clock control outputs.
	output reg        full_speed_reg,
	output reg  [2:0] usb_clock_source_reg,
	output wire [6:0] oscillator_trim_value,
	output wire       recovery_locked,
	output wire       recovery_active,
	// Frame marker pin.
	input  wire       frame_pin,
	// USB side: OUT bytes arriving from the host.
	input  wire [1:0] usb_out_ep,
	input  wire [7:0] usb_out_data,
	input  wire       usb_out_valid,
	output wire       usb_out_ready,
	// USB side: IN bytes sent to the host.
	input  wire [1:0] usb_in_ep,
	input  wire       usb_in_req,
	output reg  [7:0] usb_in_data,
	output reg        usb_in_valid,
	output reg  [9:0] usb_in_max_packet,
	output reg  [9:0] usb_out_max_packet,
	// Buffer status.
	output wire [6:0] buffer_empty,
	output wire [6:0] buffer_full
);
	// ======================================================================
	// Queue mapping helpers.
	function split_of;
		input [3:1] sm;
		input [1:0] ep;
		begin
			case (ep)
				2'd1:    split_of = sm[1];
				2'd2:    split_of = sm[2];
				2'd3:    split_of = sm[3];
				default: split_of = 1'b0;
			endcase
		end
	endfunction

	function [2:0] queue_of;
		input [1:0] ep;
		input       out_half;
		begin
			if (ep == 2'd0)
				queue_of = 3'd0;
			else if (out_half)
				queue_of = {ep, 1'b0};
			else
				queue_of = {ep, 1'b0} - 3'd1;
		end
	endfunction

	function dir_ok;
		input [1:0] ep;
		input [3:1] sm;
		input [3:1] ds;
		input       want_in;
		begin
			case (ep)
				2'd1:    dir_ok = sm[1] | (ds[1] == want_in);
				2'd2:    dir_ok = sm[2] | (ds[2] == want_in);
				2'd3:    dir_ok = sm[3] | (ds[3] == want_in);
				default: dir_ok = 1'b1;
			endcase
		end
	endfunction

	function [9:0] queue_size;
		input [2:0] q;
		input [3:1] sm;
		begin
			case (q)
				3'd1, 3'd2: queue_size = sm[1] ? (`EP1_SIZE >> 1)
					: `EP1_SIZE;
				3'd3, 3'd4: queue_size = sm[2] ? (`EP2_SIZE >> 1)
					: `EP2_SIZE;
				3'd5, 3'd6: queue_size = sm[3] ? (`EP3_SIZE >> 1)
					: `EP3_SIZE;
				default:    queue_size = `EP0_SIZE;
			endcase
		end
	endfunction

	function [9:0] queue_base;
		input [2:0] q;
		input [3:1] sm;
		begin
			case (q)
				3'd1:    queue_base = sm[1] ? `EP1_BASE + (`EP1_SIZE >> 1)
					: `EP1_BASE;
				3'd2:    queue_base = `EP1_BASE;
				3'd3:    queue_base = sm[2] ? `EP2_BASE + (`EP2_SIZE >> 1)
					: `EP2_BASE;
				3'd4:    queue_base = `EP2_BASE;
				3'd5:    queue_base = sm[3] ? `EP3_BASE + (`EP3_SIZE >> 1)
					: `EP3_BASE;
				3'd6:    queue_base = `EP3_BASE;
				default: queue_base = `EP0_BASE;
			endcase
		end
	endfunction

	function [9:0] max_packet;
		input [2:0] q;
		input [3:1] sm;
		input [3:1] ind;
		input [3:1] outd;
		reg         dbl;
		begin
			dbl = 1'b0;
			case (q)
				3'd1:    dbl = ind[1];
				3'd2:    dbl = sm[1] ? outd[1] : ind[1];
				3'd3:    dbl = ind[2];
				3'd4:    dbl = sm[2] ? outd[2] : ind[2];
				3'd5:    dbl = ind[3];
				3'd6:    dbl = sm[3] ? outd[3] : ind[3];
				default: dbl = 1'b0;
			endcase
			max_packet = dbl ? queue_size(q, sm) >> 1 : queue_size(q, sm);
		end
	endfunction

	// ======================================================================
	// Buffer RAM and per-queue state.
	reg  [7:0] buffer_ram [0:`BUFFER_BYTES-1];
	wire [9:0] wp_w  [0:6];
	wire [9:0] rp_w  [0:6];
	wire [9:0] cnt_w [0:6];
	reg  [6:0] push_vec;
	reg  [6:0] pop_vec;

	// ======================================================================
	// Recovery control register.
	reg        recovery_enable_reg;
	reg        single_step_reg;
	reg        low_speed_recovery_reg;
	wire [7:0] recovery_byte;

	assign recovery_byte = {recovery_enable_reg, single_step_reg,
		low_speed_recovery_reg, `RESERVED_PATTERN};
	assign recovery_active = recovery_enable_reg & transceiver_enable &
		(full_speed_reg | low_speed_recovery_reg);

	// ======================================================================
	// Request decode.
	wire       port_hit;
	wire [1:0] fw_ep;
	wire [2:0] fw_wq;
	wire [2:0] fw_rq;
	wire [2:0] uo_q;
	wire [2:0] ui_q;
	wire       fifo_valid;
	wire [9:0] fifo_word;
	wire       uo_allowed;
	wire       fw_push;
	wire       fw_pop;
	wire       uo_push;
	wire       ui_pop;
	wire       fifo_ready;

	assign port_hit = (reg_addr >= `BYTE_PORT_FIRST) &&
		(reg_addr <= `BYTE_PORT_LAST);
	assign fw_ep = reg_addr[1:0];
	assign fw_wq = queue_of(fw_ep, 1'b0);
	assign fw_rq = queue_of(fw_ep, split_of(split_mode, fw_ep));
	assign uo_q  = queue_of(fifo_word[9:8],
		split_of(split_mode, fifo_word[9:8]));
	assign ui_q  = queue_of(usb_in_ep, 1'b0);

	assign fw_push = reg_write & port_hit & (cnt_w[fw_wq] !=
		queue_size(fw_wq, split_mode)) & dir_ok(fw_ep, split_mode,
		endpoint_direction_select, 1'b1);
	assign fw_pop = reg_read & port_hit & (cnt_w[fw_rq] != 10'h000) &
		dir_ok(fw_ep, split_mode, endpoint_direction_select,
		1'b0);
	assign uo_allowed = dir_ok(fifo_word[9:8], split_mode,
		endpoint_direction_select, 1'b0);
	assign uo_push = fifo_valid & uo_allowed & ~fw_push &
		(cnt_w[uo_q] != queue_size(uo_q, split_mode));
	assign fifo_ready = ~uo_allowed | (~fw_push &
		(cnt_w[uo_q] != queue_size(uo_q, split_mode)));
	assign ui_pop = usb_in_req & (cnt_w[ui_q] != 10'h000) &
		~(fw_pop && (fw_rq == ui_q)) & dir_ok(usb_in_ep, split_mode,
		endpoint_direction_select, 1'b1);

	always @*
	begin
		push_vec = 7'h00;
		pop_vec  = 7'h00;
		if (fw_push)
			push_vec[fw_wq] = 1'b1;
		if (uo_push)
			push_vec[uo_q] = 1'b1;
		if (fw_pop)
			pop_vec[fw_rq] = 1'b1;
		if (ui_pop)
			pop_vec[ui_q] = 1'b1;
	end

	// ======================================================================
	// Queue pointers, one set for endpoint zero and one per buffer half of endpoints 1 to 3.
	genvar g;
	generate
		for (g = 0; g < 7; g = g + 1)
		begin : queue
			reg  [9:0] wp_reg;
			reg  [9:0] rp_reg;
			reg  [9:0] cnt_reg;
			wire [9:0] size;
			localparam [2:0] QUEUE_INDEX = g;

			assign size      = queue_size(QUEUE_INDEX, split_mode);
			assign wp_w[g]   = wp_reg;
			assign rp_w[g]   = rp_reg;
			assign cnt_w[g]  = cnt_reg;
			assign buffer_empty[g] = (cnt_reg == 10'h000);
			assign buffer_full[g]  = (cnt_reg == size);

			always @(posedge core_clk)
			begin
				if (!resetn)
				begin
					wp_reg  <= 10'h000;
					rp_reg  <= 10'h000;
					cnt_reg <= 10'h000;
				end
				else
				begin
					if (push_vec[g])
						wp_reg <= (wp_reg + 10'h001 == size) ? 10'h000
							: wp_reg + 10'h001;
					if (pop_vec[g])
						rp_reg <= (rp_reg + 10'h001 == size) ? 10'h000
							: rp_reg + 10'h001;
					if (push_vec[g] && !pop_vec[g])
						cnt_reg <= cnt_reg + 10'h001;
					else if (pop_vec[g] && !push_vec[g])
						cnt_reg <= cnt_reg - 10'h001;
				end
			end
		end
	endgenerate

	// ======================================================================
	// Buffer RAM write port, firmware first.
	always @(posedge core_clk)
	begin
		if (fw_push)
			buffer_ram[queue_base(fw_wq, split_mode) + wp_w[fw_wq]]
				<= reg_wdata;
		else if (uo_push)
			buffer_ram[queue_base(uo_q, split_mode) + wp_w[uo_q]]
				<= fifo_word[7:0];
	end

	// ======================================================================
	// Register reads, writes and USB-side reads.
	always @(posedge core_clk)
	begin
		if (!resetn)
		begin
			recovery_enable_reg    <= 1'b0;
			single_step_reg        <= 1'b0;
			low_speed_recovery_reg <= 1'b0;
			reg_rdata              <= 8'h00;
			usb_in_data            <= 8'h00;
			usb_in_valid           <= 1'b0;
			full_speed_reg         <= 1'b0;
			usb_clock_source_reg   <= 3'h0;
			usb_in_max_packet      <= 10'h000;
			usb_out_max_packet     <= 10'h000;
		end
		else
		begin
			full_speed_reg       <= speed_select;
			usb_clock_source_reg <= clock_select;
			usb_in_max_packet    <= max_packet(ui_q, split_mode,
				in_double_buffer, out_double_buffer);
			usb_out_max_packet   <= max_packet(queue_of(usb_out_ep,
				split_of(split_mode, usb_out_ep)), split_mode,
				in_double_buffer, out_double_buffer);
			if (reg_write && reg_addr == `CLOCK_RECOVERY_ADDR)
			begin
				recovery_enable_reg    <= reg_wdata[`RECOVERY_ENABLE_BIT];
				single_step_reg        <= reg_wdata[`SINGLE_STEP_BIT];
				low_speed_recovery_reg <= reg_wdata[`LOW_SPEED_RECOVERY_BIT];
			end
			if (reg_read && reg_addr == `CLOCK_RECOVERY_ADDR)
				reg_rdata <= recovery_byte;
			else if (fw_pop)
				reg_rdata <= buffer_ram[queue_base(fw_rq, split_mode) +
					rp_w[fw_rq]];
			else if (reg_read)
				reg_rdata <= 8'h00;
			usb_in_valid <= ui_pop;
			if (ui_pop)
				usb_in_data <= buffer_ram[queue_base(ui_q, split_mode) +
					rp_w[ui_q]];
		end
	end

	// ======================================================================
	// OUT byte staging and oscillator trim.
	byte_fifo
	#(
		.WIDTH (10),
		.DEPTH (FIFO_DEPTH),
		.AW    (4)
	)
	u_out_fifo
	(
		.core_clk  (core_clk),
		.resetn    (resetn),
		.in_valid  (usb_out_valid),
		.in_data   ({usb_out_ep, usb_out_data}),
		.in_ready  (usb_out_ready),
		.out_valid (fifo_valid),
		.out_data  (fifo_word),
		.out_ready (fifo_ready)
	);

	oscillator_trim
	#(
		.FRAME_CYCLES (FRAME_CYCLES),
		.CNT_W        (20)
	)
	u_trim
	(
		.core_clk    (core_clk),
		.resetn      (resetn),
		.recovery_on (recovery_active),
		.single_step (single_step_reg),
		.frame_pin   (frame_pin),
		.trim_reg    (oscillator_trim_value),
		.locked_reg  (recovery_locked)
	);
endmodule // usb_endpoint_buffer
